//--- hdl/bsc_map.svh
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BSC_CLK_MHZ 250
`define BSC_PRESS_QUAL_MS 1000
`define BSC_LIMIT_BLANK_MS 2000

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BSC_ADDR_CTRL 4'h0
`define BSC_ADDR_STATUS 4'h1
`define BSC_ADDR_IRQ_STAT 4'h2
`define BSC_ADDR_IRQ_EN 4'h3
`define BSC_ADDR_IRQ_CLR 4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BSC_CTRL_VAR_LSB 0
`define BSC_CTRL_ACTIVE_BIT 3
`define BSC_CTRL_FCLR_BIT 4
`define BSC_IRQ_FULL_BIT 0
`define BSC_IRQ_STROKE_BIT 1
`define BSC_IRQ_HOT_BIT 2
`define BSC_IRQ_LOCK_BIT 3
`define BSC_STAT_STATE_LSB 0
`define BSC_STAT_STAGE_LSB 2
`define BSC_STAT_FULL_BIT 4
`define BSC_STAT_LOCK_BIT 5
`define BSC_STAT_HOT_BIT 6
`define BSC_STAT_LIMIT_BIT 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BSC_CTRL_RST 8'h00
`define BSC_IRQ_EN_RST 8'h00

`endif

//--- hdl/bsc_pkg.sv
package bsc_pkg;

   // Stroke sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DOWN,
      ST_TURN,
      ST_UP
   } bsc_state_type;

   // Full-bale policy variants
   typedef enum logic [2:0] {
      VAR_NO_LOCK,
      VAR_THREE,
      VAR_SINGLE,
      VAR_LEG_EARLY,
      VAR_LEG_LATE
   } bsc_variant_type;

   // Display message selection
   typedef enum logic [2:0] {
      MSG_NONE,
      MSG_FULL_FIRST,
      MSG_FULL_SECOND,
      MSG_FULL_THIRD,
      MSG_FULL_THIRD_ALT,
      MSG_FULL_SINGLE,
      MSG_HOT
   } bsc_msg_type;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bsc_bus_req_type;

   // Machine contact inputs
   typedef struct packed {
      logic press_n;
      logic limit_n;
      logic thermal_n;
      logic ir_blocked;
   } bsc_pins_type;

   // Cylinder drive outputs
   typedef struct packed {
      logic motor_run;
      logic dir_down;
      logic stroke_end;
   } bsc_drive_type;

endpackage

//--- hdl/bsc_sync.sv
`timescale 1ns/1ps

module bsc_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q_r
);

   logic [W-1:0] meta_r;

   // Two-stage synchroniser, first stage read only by second
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

endmodule

//--- hdl/bsc_qual.sv
`timescale 1ns/1ps

module bsc_qual #(
   parameter int unsigned CYC = 1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic en,
   input wire logic level,
   output logic qual_r
);

   logic [31:0] cnt_r;

   // Level must hold unbroken for CYC cycles, then latches until en drops
   always_ff @(posedge clk_sys) begin
      if (!nrst || !en) begin
         cnt_r <= 32'h0;
         qual_r <= 1'b0;
      end else if (!qual_r) begin
         if (!level) begin
            cnt_r <= 32'h0;
         end else if (cnt_r >= CYC - 1) begin
            qual_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 32'h1;
         end
      end
   end

endmodule

//--- hdl/bsc_ctrl.sv
// Function
// RQ1 - Down stroke: pressure before limit closure means the bale is full.
// RQ2 - End up or down stroke on limit or pressure, whichever comes first.
// RQ3 - A closed limit contact means the cylinder reached end of travel.
// RQ4 - Limit variants read the old full-bale input as the limit switch.
// RQ5 - Three-cycle variant allows three cycles after full, first/second/third message.
// RQ6 - Three-cycle variant refuses new cycles once third message shows.
// RQ7 - Single-cycle variant allows one cycle, one message, then locks out.
// RQ8 - No-lock variant shows no full message and never locks out.
// RQ9 - Legacy variants ignore the limit switch, end strokes on pressure only.
// RQ10 - Early legacy variant never locks out after full.
// RQ11 - Late legacy variant locks out on full, showing the third message.
// RQ12 - Pressure counts only after one second unbroken low, then latches.
// RQ13 - Limit input ignored for two seconds at each stroke start.
// RQ14 - Active and not full: keep cycling while the hopper beam is blocked.
// RQ15 - Over-temperature halts everything and selects the hot message.
// RQ16 - Policy variant selected by configuration: none, three, single, legacy.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps

`include "bsc_map.svh"

module bsc_ctrl #(
   parameter int unsigned PRESS_QUAL_CYC = `BSC_PRESS_QUAL_MS * `BSC_CLK_MHZ * 1000,
   parameter int unsigned LIMIT_BLANK_CYC = `BSC_LIMIT_BLANK_MS * `BSC_CLK_MHZ * 1000
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire bsc_pkg::bsc_bus_req_type bus_req,
   output logic [7:0] bus_rdata_r,
   input wire bsc_pkg::bsc_pins_type pins,
   output bsc_pkg::bsc_drive_type drive_r,
   output bsc_pkg::bsc_msg_type msg_sel_r,
   output logic cycle_ok_r,
   output logic irq_r
);
   import bsc_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   bsc_state_type state_r;
   bsc_state_type state_nxt;
   bsc_variant_type var_r;
   logic active_r;
   logic [3:0] pin_s;
   logic press_lvl;
   logic limit_closed;
   logic hot;
   logic ir_blocked;
   logic in_stroke;
   logic press_qual;
   logic [31:0] blank_cnt_r;
   logic blank_done;
   logic limit_var;
   logic limit_hit;
   logic stroke_done;
   logic full_evt;
   logic full_r;
   logic [1:0] stage_r;
   logic lockout;
   logic start;
   logic full_clr;
   logic hot_d_r;
   logic lock_d_r;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_en_r;
   logic [3:0] irq_ev;
   logic [3:0] irq_clr;
   logic wr_ctrl;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------

   // Contacts pull sense wires low when closed; invert to active high
   bsc_sync #(
      .W(4)
   ) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .d({~pins.press_n, ~pins.limit_n, ~pins.thermal_n, pins.ir_blocked}),
      .q_r(pin_s)
   );

   // RQ3 closed means end
   assign limit_closed = pin_s[2];
   assign press_lvl = pin_s[3];
   assign hot = pin_s[1];
   assign ir_blocked = pin_s[0];

   // ----------------------------------------------------------------
   // Pressure qualification
   // ----------------------------------------------------------------
   assign in_stroke = (state_r == ST_DOWN) || (state_r == ST_UP);

   // RQ12 one second qualify
   bsc_qual #(
      .CYC(PRESS_QUAL_CYC)
   ) u_press (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .en(in_stroke),
      .level(press_lvl),
      .qual_r(press_qual)
   );

   // ----------------------------------------------------------------
   // Limit switch blanking
   // ----------------------------------------------------------------

   // RQ13 blank stroke start
   always_ff @(posedge clk_sys) begin
      if (!nrst || !in_stroke) begin
         blank_cnt_r <= 32'h0;
      end else if (blank_cnt_r < LIMIT_BLANK_CYC) begin
         blank_cnt_r <= blank_cnt_r + 32'h1;
      end
   end

   assign blank_done = (blank_cnt_r >= LIMIT_BLANK_CYC);

   // RQ4 RQ9 variant input use
   assign limit_var = (var_r == VAR_NO_LOCK) || (var_r == VAR_THREE) ||
                      (var_r == VAR_SINGLE);
   assign limit_hit = limit_var && blank_done && limit_closed;

   // RQ2 RQ9 stroke termination
   assign stroke_done = in_stroke && (press_qual || limit_hit);

   // RQ1 full on pressure first
   always_comb begin
      full_evt = 1'b0;
      if (state_r == ST_DOWN && press_qual) begin
         if (limit_var) begin
            full_evt = !limit_hit;
         end else begin
            full_evt = !limit_closed;
         end
      end
   end

   // ----------------------------------------------------------------
   // Lock-out policy
   // ----------------------------------------------------------------

   // RQ6 RQ7 RQ8 RQ10 RQ11 lock-out per variant
   always_comb begin
      case (var_r)
         VAR_THREE: lockout = (stage_r == 2'd3);
         VAR_SINGLE: lockout = (stage_r == 2'd1);
         VAR_LEG_LATE: lockout = (stage_r == 2'd3);
         VAR_NO_LOCK: lockout = 1'b0;
         VAR_LEG_EARLY: lockout = 1'b0;
         default: lockout = 1'b0;
      endcase
   end

   // RQ14 cycle on blocked beam
   assign start = (state_r == ST_IDLE) && active_r && ir_blocked && !lockout && !hot;

   // Full state and stage count, a new full bale wins over a clear
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         full_r <= 1'b0;
         stage_r <= 2'd0;
      end else if (full_evt && (!full_r || full_clr)) begin
         full_r <= 1'b1;
         // RQ11 legacy lock at once
         stage_r <= (var_r == VAR_LEG_LATE) ? 2'd3 : 2'd0;
      end else if (full_clr) begin
         full_r <= 1'b0;
         stage_r <= 2'd0;
      end else if (start && full_r) begin
         // RQ5 count further cycles
         if (var_r == VAR_THREE && stage_r != 2'd3) begin
            stage_r <= stage_r + 2'd1;
         end else if (var_r == VAR_SINGLE && stage_r == 2'd0) begin
            // RQ7 single further cycle
            stage_r <= 2'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Stroke sequencer
   // ----------------------------------------------------------------

   // Next state: down, one-cycle valve turn, up, idle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start) begin
               state_nxt = ST_DOWN;
            end
         end
         ST_DOWN: begin
            if (stroke_done) begin
               state_nxt = ST_TURN;
            end
         end
         ST_TURN: state_nxt = ST_UP;
         ST_UP: begin
            if (stroke_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // RQ15 halt on heat
      if (hot) begin
         state_nxt = ST_IDLE;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Cylinder drive outputs
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         drive_r <= '0;
      end else begin
         drive_r.motor_run <= (state_nxt == ST_DOWN) || (state_nxt == ST_UP);
         drive_r.dir_down <= (state_nxt == ST_DOWN);
         // RQ2 end pulse
         drive_r.stroke_end <= stroke_done;
      end
   end

   // ----------------------------------------------------------------
   // Display and permission
   // ----------------------------------------------------------------

   // Message selection, heat first
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         msg_sel_r <= MSG_NONE;
      end else if (hot) begin
         // RQ15 hot message
         msg_sel_r <= MSG_HOT;
      end else begin
         case (var_r)
            VAR_THREE: begin
               // RQ5 RQ6 staged messages
               case (stage_r)
                  2'd1: msg_sel_r <= MSG_FULL_FIRST;
                  2'd2: msg_sel_r <= MSG_FULL_SECOND;
                  2'd3: msg_sel_r <= (state_nxt == ST_IDLE) ? MSG_FULL_THIRD_ALT :
                                     MSG_FULL_THIRD;
                  default: msg_sel_r <= MSG_NONE;
               endcase
            end
            // RQ7 single message
            VAR_SINGLE: msg_sel_r <= (stage_r == 2'd1) ? MSG_FULL_SINGLE : MSG_NONE;
            // RQ11 third as lock-out
            VAR_LEG_LATE: msg_sel_r <= (stage_r == 2'd3) ? MSG_FULL_THIRD : MSG_NONE;
            // RQ8 RQ10 no full message
            default: msg_sel_r <= MSG_NONE;
         endcase
      end
   end

   // Cycle permission level
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cycle_ok_r <= 1'b0;
      end else begin
         cycle_ok_r <= active_r && !lockout && !hot;
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   assign wr_ctrl = bus_req.wr && (bus_req.addr == `BSC_ADDR_CTRL);
   assign full_clr = wr_ctrl && bus_req.wdata[`BSC_CTRL_FCLR_BIT];

   // RQ16 variant select
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         var_r <= bsc_variant_type'(3'(`BSC_CTRL_RST));
         active_r <= 1'b0;
      end else if (wr_ctrl) begin
         var_r <= bsc_variant_type'(bus_req.wdata[`BSC_CTRL_VAR_LSB +: 3]);
         active_r <= bus_req.wdata[`BSC_CTRL_ACTIVE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------

   // Edge history for heat and lock-out events
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         hot_d_r <= 1'b0;
         lock_d_r <= 1'b0;
      end else begin
         hot_d_r <= hot;
         lock_d_r <= lockout;
      end
   end

   always_comb begin
      irq_ev = 4'h0;
      irq_ev[`BSC_IRQ_FULL_BIT] = full_evt && (!full_r || full_clr);
      irq_ev[`BSC_IRQ_STROKE_BIT] = stroke_done;
      irq_ev[`BSC_IRQ_HOT_BIT] = hot && !hot_d_r;
      irq_ev[`BSC_IRQ_LOCK_BIT] = lockout && !lock_d_r;
   end

   assign irq_clr = (bus_req.wr && bus_req.addr == `BSC_ADDR_IRQ_CLR) ?
                    bus_req.wdata[3:0] : 4'h0;

   // Sticky status, a new event wins over a clear
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_stat_r <= 4'h0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      end
   end

   // Enable register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_en_r <= 4'(`BSC_IRQ_EN_RST);
      end else if (bus_req.wr && bus_req.addr == `BSC_ADDR_IRQ_EN) begin
         irq_en_r <= bus_req.wdata[3:0];
      end
   end

   // Level interrupt from updated status
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_en_r);
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         bus_rdata_r <= 8'h00;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            `BSC_ADDR_CTRL: bus_rdata_r <= {4'h0, active_r, var_r};
            `BSC_ADDR_STATUS: bus_rdata_r <= {limit_closed, hot, lockout, full_r,
                                              stage_r, state_r};
            `BSC_ADDR_IRQ_STAT: bus_rdata_r <= {4'h0, irq_stat_r};
            `BSC_ADDR_IRQ_EN: bus_rdata_r <= {4'h0, irq_en_r};
            default: bus_rdata_r <= 8'h00;
         endcase
      end else begin
         bus_rdata_r <= 8'h00;
      end
   end

endmodule

//--- test/bsc_ctrl_sva.sv
`timescale 1ns/1ps

module bsc_ctrl_chk #(
   parameter int unsigned PRESS_QUAL_CYC = 3,
   parameter int unsigned LIMIT_BLANK_CYC = 5
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire bsc_pkg::bsc_bus_req_type bus_req,
   input wire logic [7:0] bus_rdata_r,
   input wire bsc_pkg::bsc_pins_type pins,
   input wire bsc_pkg::bsc_drive_type drive_r,
   input wire bsc_pkg::bsc_msg_type msg_sel_r,
   input wire logic cycle_ok_r,
   input wire logic irq_r
);
   import bsc_pkg::*;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // Idle, permitted and hopper blocked for four cycles
   sequence s_idle_wait;
      (pins.ir_blocked && cycle_ok_r && !drive_r.motor_run)[*4];
   endsequence
   // Thermal contact held closed
   sequence s_hot_held;
      (!pins.thermal_n)[*6];
   endsequence
   property p_start;
      s_idle_wait |-> ##[0:4] drive_r.motor_run;
   endproperty
   a_start: assert property (p_start) else $error("press cycle not started");
   property p_hot;
      s_hot_held |-> !drive_r.motor_run && !cycle_ok_r && msg_sel_r == MSG_HOT;
   endproperty
   a_hot: assert property (p_hot) else $error("hot did not halt");
   property p_end_fall;
      drive_r.stroke_end |-> !drive_r.motor_run && $past(drive_r.motor_run);
   endproperty
   a_end_fall: assert property (p_end_fall) else $error("stroke end without stop");
   property p_turn;
      $rose(drive_r.motor_run) && !drive_r.dir_down |-> $past(drive_r.stroke_end);
   endproperty
   a_turn: assert property (p_turn) else $error("up stroke without down end");
   property p_end_cause;
      drive_r.stroke_end |-> !$past(pins.limit_n, 3) || (!$past(pins.press_n, 4) &&
         !$past(pins.press_n, 5) && !$past(pins.press_n, 6));
   endproperty
   a_end_cause: assert property (p_end_cause) else $error("stroke end without cause");
   property p_blank;
      $rose(drive_r.motor_run) |-> !drive_r.stroke_end [*5];
   endproperty
   a_blank: assert property (p_blank) else $error("stroke ended inside blanking");
   property p_lock;
      $rose(drive_r.motor_run && drive_r.dir_down) |-> cycle_ok_r || $past(cycle_ok_r);
   endproperty
   a_lock: assert property (p_lock) else $error("cycle started while locked");
   property p_msg_order;
      $changed(msg_sel_r) && msg_sel_r == MSG_FULL_SECOND |-> $past(msg_sel_r) == MSG_FULL_FIRST;
   endproperty
   a_msg_order: assert property (p_msg_order) else $error("second message out of order");
   property p_rdata;
      !$past(bus_req.rd) |-> bus_rdata_r == 8'h00;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule

bind bsc_ctrl bsc_ctrl_chk #(.PRESS_QUAL_CYC(PRESS_QUAL_CYC), .LIMIT_BLANK_CYC(LIMIT_BLANK_CYC))
   u_chk (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_rdata_r(bus_rdata_r),
   .pins(pins), .drive_r(drive_r), .msg_sel_r(msg_sel_r), .cycle_ok_r(cycle_ok_r),
   .irq_r(irq_r));

//--- test/bsc_switch_model.sv
`timescale 1ns/1ps

module bsc_switch_model (
   input wire logic clk_sys,
   input wire bsc_pkg::bsc_drive_type drive,
   input var int press_at,
   input var int limit_at,
   output logic press_n,
   output logic limit_n
);
   import bsc_pkg::*;
   int cnt = 0;
   // Contacts open at power up, sense lines pulled high
   initial begin
      press_n = 1'b1;
      limit_n = 1'b1;
   end
   // Stroke time, pressure only while pumping
   always @(posedge clk_sys) begin
      cnt <= (drive.motor_run === 1'b1) ? cnt + 1 : 0;
      press_n <= !(drive.motor_run === 1'b1 && cnt >= press_at);
   end
   // One end stop: opens on the first edge of the next stroke, well inside blanking
   always @(posedge clk_sys) begin
      if (drive.motor_run === 1'b1 && cnt == 0) begin
         limit_n <= 1'b1;
      end
      if (drive.motor_run === 1'b1 && limit_at != 0 && cnt == limit_at) begin
         limit_n <= 1'b0;
      end
   end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps

`include "bsc_map.svh"

module tb;
   import bsc_pkg::*;
   logic clk_sys, nrst, thermal_n, ir_blocked, press_n, limit_n, cycle_ok_r, irq_r;
   logic [7:0] bus_rdata_r;
   bsc_bus_req_type bus_req;
   bsc_drive_type drive_r;
   bsc_msg_type msg_sel_r;
   int press_at, limit_at, failures, cmp_count, cyc;
   wire bsc_pins_type pins = {press_n, limit_n, thermal_n, ir_blocked};
   bsc_ctrl #(.PRESS_QUAL_CYC(3), .LIMIT_BLANK_CYC(5)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
      .bus_req(bus_req), .bus_rdata_r(bus_rdata_r), .pins(pins), .drive_r(drive_r),
      .msg_sel_r(msg_sel_r), .cycle_ok_r(cycle_ok_r), .irq_r(irq_r));
   bsc_switch_model i_sw (.clk_sys(clk_sys), .drive(drive_r), .press_at(press_at),
      .limit_at(limit_at), .press_n(press_n), .limit_n(limit_n));
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      tick();
      bus_req.wr <= 1'b0;
      tick();
   endtask
   task automatic rd(logic [3:0] a, output logic [7:0] d);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      tick();
      d = bus_rdata_r;
      bus_req.rd <= 1'b0;
      tick();
   endtask
   // One press cycle: message at down end, down stroke length
   task automatic one_cycle(output bsc_msg_type m, output int len);
      int n, e;
      n = 0;
      e = 0;
      len = 0;
      m = MSG_NONE;
      while (drive_r.motor_run !== 1'b1 && n < 300) begin
         tick();
         n++;
      end
      while (e < 2 && n < 300) begin
         tick();
         n++;
         if (drive_r.stroke_end === 1'b1) begin
            e++;
            if (e == 1) m = msg_sel_r;
         end
         if (e == 0) len++;
      end
      chk(8'(n < 300), 8'h01);
   endtask
   // Normal cycle, full cycle, then the policy's follow-up cycles
   task automatic run_variant(logic [2:0] v, int n, bsc_msg_type ex [3], logic lock,
      bsc_msg_type lk);
      bsc_msg_type m;
      int len;
      logic [7:0] d;
      logic ran;
      wr(`BSC_ADDR_IRQ_CLR, 8'h0F);
      wr(`BSC_ADDR_CTRL, {3'h0, 2'b11, v});
      one_cycle(m, len);
      press_at <= 2;
      limit_at <= 0;
      if (v < 3) chk(8'(len > 5 && len < 15), 8'h01);
      else chk(8'(len > 15), 8'h01);
      rd(`BSC_ADDR_STATUS, d);
      chk({7'h00, d[4]}, 8'h00);
      rd(`BSC_ADDR_IRQ_STAT, d);
      chk({7'h00, d[`BSC_IRQ_FULL_BIT]}, 8'h00);
      one_cycle(m, len);
      press_at <= 15;
      limit_at <= 6;
      rd(`BSC_ADDR_STATUS, d);
      chk({7'h00, d[4]}, 8'h01);
      rd(`BSC_ADDR_IRQ_STAT, d);
      chk({7'h00, d[`BSC_IRQ_FULL_BIT]}, 8'h01);
      for (int i = 0; i < n; i++) begin
         one_cycle(m, len);
         chk(8'(m), 8'(ex[i]));
      end
      ran = 1'b0;
      repeat (30) begin
         tick();
         ran |= drive_r.motor_run;
      end
      chk({7'h00, ran}, {7'h00, !lock});
      if (lock) chk(8'(msg_sel_r), 8'(lk));
      wr(`BSC_ADDR_CTRL, 8'h10);
      repeat (60) tick();
   endtask
   // Over-temperature halt and the interrupt path
   task automatic t_hot();
      logic [7:0] d;
      wr(`BSC_ADDR_IRQ_CLR, 8'h0F);
      wr(`BSC_ADDR_IRQ_EN, 8'h04);
      wr(`BSC_ADDR_CTRL, 8'h0B);
      repeat (12) tick();
      thermal_n <= 1'b0;
      repeat (6) tick();
      chk({7'h00, drive_r.motor_run}, 8'h00);
      chk(8'(msg_sel_r), 8'(MSG_HOT));
      rd(`BSC_ADDR_IRQ_STAT, d);
      chk(d, 8'h04);
      chk({7'h00, irq_r}, 8'h01);
      wr(`BSC_ADDR_IRQ_EN, 8'h00);
      chk({7'h00, irq_r}, 8'h00);
      wr(`BSC_ADDR_IRQ_EN, 8'h04);
      chk({7'h00, irq_r}, 8'h01);
      wr(`BSC_ADDR_IRQ_CLR, 8'h04);
      chk({7'h00, irq_r}, 8'h00);
      rd(`BSC_ADDR_IRQ_STAT, d);
      chk(d, 8'h00);
      thermal_n <= 1'b1;
   endtask
   task automatic tally_and_finish();
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      logic [7:0] d;
      nrst = 1'b0;
      bus_req = '0;
      thermal_n = 1'b1;
      ir_blocked = 1'b0;
      press_at = 15;
      limit_at = 6;
      repeat (8) tick();
      nrst <= 1'b1;
      tick();
      rd(`BSC_ADDR_CTRL, d);
      chk(d, `BSC_CTRL_RST);
      rd(`BSC_ADDR_IRQ_EN, d);
      chk(d, `BSC_IRQ_EN_RST);
      rd(4'hF, d);
      chk(d, 8'h00);
      wr(`BSC_ADDR_CTRL, 8'h04);
      rd(`BSC_ADDR_CTRL, d);
      chk(d, 8'h04);
      ir_blocked <= 1'b1;
      run_variant(3'h0, 3, '{MSG_NONE, MSG_NONE, MSG_NONE}, 1'b0, MSG_NONE);
      run_variant(3'h1, 3, '{MSG_FULL_FIRST, MSG_FULL_SECOND, MSG_FULL_THIRD}, 1'b1,
         MSG_FULL_THIRD_ALT);
      run_variant(3'h2, 1, '{MSG_FULL_SINGLE, MSG_NONE, MSG_NONE}, 1'b1, MSG_FULL_SINGLE);
      run_variant(3'h3, 3, '{MSG_NONE, MSG_NONE, MSG_NONE}, 1'b0, MSG_NONE);
      run_variant(3'h4, 0, '{MSG_NONE, MSG_NONE, MSG_NONE}, 1'b1, MSG_FULL_THIRD);
      t_hot();
      tally_and_finish();
   end
endmodule
